// ===== dtc_pkg.sv
`default_nettype none
package dtc_pkg;
    // Register byte addresses (classic Wishbone, one aligned word each except ADDR_MODE, which shares the 8'h88 word)
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_CNT0_LO = 8'h8c;
    localparam logic [7:0] ADDR_CNT1_LO = 8'h90;
    localparam logic [7:0] ADDR_CNT0_HI = 8'h94;
    localparam logic [7:0] ADDR_CNT1_HI = 8'h98;
    localparam logic [7:0] ADDR_IRQ_ACK = 8'h9c;
    // Control register fields
    localparam int OVF1_BIT = 7;
    localparam int RUN1_BIT = 6;
    localparam int OVF0_BIT = 5;
    localparam int RUN0_BIT = 4;
    localparam int EXT1_FLAG_BIT = 3;
    localparam int EXT1_TYPE_BIT = 2;
    localparam int EXT0_FLAG_BIT = 1;
    localparam int EXT0_TYPE_BIT = 0;
    // Mode register fields, per timer nibble
    localparam int MODE1_LSB = 4;
    localparam int MODE0_LSB = 0;
    localparam int GATE_OFS = 3;
    localparam int SEL_OFS = 2;
    // Service acknowledge bits
    localparam int ACK_OVF0_BIT = 0;
    localparam int ACK_OVF1_BIT = 1;
    localparam int ACK_EXT0_BIT = 2;
    localparam int ACK_EXT1_BIT = 3;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Timing: oscillator periods per machine cycle
    localparam int OSC_PER_MCYCLE = 6;
    localparam logic [2:0] MCYCLE_LAST = 3'(OSC_PER_MCYCLE - 1);
    // Count modes
    typedef enum logic [1:0] {
        DTC_MODE_13 = 2'b00,
        DTC_MODE_16 = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_e;
endpackage
`default_nettype wire

// ===== dtc_sync.sv
`default_nettype none
module dtc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Level in and out
    input wire logic din,
    output logic dout
);
    import dtc_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
    } dtc_sync_s;
    dtc_sync_s r, next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Idle high: a low reset level would fake a level interrupt after reset
            r <= '1;
        end else begin
            r <= next_r;
        end
    end
    assign dout = r.s2;
endmodule
`default_nettype wire

// ===== dtc_edge.sv
`default_nettype none
module dtc_edge (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Synchronised pin level and sample strobe
    input wire logic level,
    input wire logic sample,
    // One-cycle pulse after a high sample followed by a low sample
    output logic fall
);
    import dtc_pkg::*;
    typedef struct packed {
        logic last;
        logic fall;
    } dtc_edge_s;
    dtc_edge_s r, next_r;
    always_comb begin
        next_r = r;
        next_r.fall = 1'b0;
        if (sample) begin
            next_r.fall = r.last && !level;
            next_r.last = level;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign fall = r.fall; // RL3
endmodule
`default_nettype wire

// ===== dtc_top.sv
// Behaviour
// (RL1) Timer mode advances once per machine cycle
// (RL2) Counter mode samples pin, counts falling edge
// (RL3) Edge count appears next machine cycle
// (RL4) Source holds each level one machine cycle
// (RL5) Mode register: gate, select, two mode bits
// (RL6) Count while run and (no gate or pin)
// (RL7) Select bit chooses core clock or pin
// (RL8) Modes: 13-bit, 16-bit, reload, split
// (RL9) 13-bit uses high byte plus low five
// (RL10) Rollover sets the overflow flag
// (RL11) Overflow flag cleared by service or software
// (RL12) Setting run keeps count registers
// (RL13) 16-bit mode uses both full bytes
// (RL14) Reload mode reloads low from high
// (RL15) Timer one in mode three holds
// (RL16) Split: low byte timer, high byte uses one's controls
// (RL17) Timer one runs outside mode three, overflows out
// (RL18) Run bits are software read/write
// (RL19) External flags set by edge or level
// (RL20) Type bit: set edge, clear level
// (RL21) Software writes load count bytes
//
// The implementer's own choice: register access over Wishbone.
`default_nettype none
module dtc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // External pins
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    // Events to the core
    output logic timer_one_overflow,
    output logic overflow_flag_zero,
    output logic overflow_flag_one,
    output logic ext_irq_flag_zero,
    output logic ext_irq_flag_one
);
    import dtc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] phase;
        logic [7:0] timer_run_and_flag_control;
        logic [7:0] timer_mode_select;
        logic [7:0] count_low_byte0;
        logic [7:0] count_high_byte0;
        logic [7:0] count_low_byte1;
        logic [7:0] count_high_byte1;
        logic irq_last0;
        logic irq_last1;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic ovf1_pulse;
    } dtc_top_s;
    dtc_top_s r, next_r;

    // ------------------------------------------------------------
    // Pin synchronisers and edge samplers
    // ------------------------------------------------------------
    logic cnt0_s, cnt1_s, irq0_s, irq1_s;
    logic cnt0_fall, cnt1_fall;
    logic mcycle;

    dtc_sync u_sync_c0 (.mclk(mclk), .srst(srst), .din(count_pin_zero), .dout(cnt0_s));
    dtc_sync u_sync_c1 (.mclk(mclk), .srst(srst), .din(count_pin_one), .dout(cnt1_s));
    dtc_sync u_sync_i0 (.mclk(mclk), .srst(srst), .din(ext_irq_pin_zero), .dout(irq0_s));
    dtc_sync u_sync_i1 (.mclk(mclk), .srst(srst), .din(ext_irq_pin_one), .dout(irq1_s));

    // One sample per machine cycle; a hit counts in the next one
    assign mcycle = (r.phase == MCYCLE_LAST); // RL1
    dtc_edge u_edge0 (.mclk(mclk), .srst(srst), .level(cnt0_s), .sample(mcycle),
        .fall(cnt0_fall)); // RL2
    dtc_edge u_edge1 (.mclk(mclk), .srst(srst), .level(cnt1_s), .sample(mcycle),
        .fall(cnt1_fall)); // RL2

    // ------------------------------------------------------------
    // Count enables
    // ------------------------------------------------------------
    logic [3:0] cfg0, cfg1;
    logic run0, run1, en0, en1, en0_hi;
    logic tick0, tick1, tick0_hi;
    dtc_mode_e mode0, mode1;

    always_comb begin
        cfg0 = r.timer_mode_select[MODE0_LSB +: 4]; // RL5
        cfg1 = r.timer_mode_select[MODE1_LSB +: 4]; // RL5
        mode0 = dtc_mode_e'(cfg0[1:0]);
        mode1 = dtc_mode_e'(cfg1[1:0]);
        run0 = r.timer_run_and_flag_control[RUN0_BIT]; // RL18
        run1 = r.timer_run_and_flag_control[RUN1_BIT]; // RL18
        en0 = run0 && (!cfg0[GATE_OFS] || irq0_s); // RL6
        en1 = run1 && (!cfg1[GATE_OFS] || irq1_s); // RL6
        // In split mode timer one's run bit belongs to the high byte of timer zero
        if (mode0 == DTC_MODE_SPLIT) begin
            en1 = !cfg1[GATE_OFS] || irq1_s; // RL17
            en0_hi = run1; // RL16
        end else begin
            en0_hi = 1'b0;
        end
        // Timer one in mode three acts as if its run bit were clear
        if (mode1 == DTC_MODE_SPLIT) begin
            en1 = 1'b0; // RL15
        end
        tick0 = en0 && (cfg0[SEL_OFS] ? cnt0_fall : mcycle); // RL7
        tick1 = en1 && (cfg1[SEL_OFS] ? cnt1_fall : mcycle); // RL7
        tick0_hi = en0_hi && mcycle; // RL16
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req, wr, hit;
    logic [7:0] wbyte;
    logic [7:0] ack_bits;
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !r.ack && !r.err;
        wr = req && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        case (wb_adr_i)
            ADDR_CTRL, ADDR_MODE, ADDR_CNT0_LO, ADDR_CNT1_LO,
            ADDR_CNT0_HI, ADDR_CNT1_HI, ADDR_IRQ_ACK: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // Service writes stand in for the processor entering a routine
        ack_bits = (wr && wb_adr_i == ADDR_IRQ_ACK) ? wbyte : 8'h00;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [8:0] sum_lo0, sum_lo1, sum_hi0, sum_hi1;
    logic ovf0, ovf1;
    logic ext_set0, ext_set1;
    logic [7:0] ctl;

    always_comb begin
        next_r = r;
        next_r.phase = mcycle ? 3'h0 : r.phase + 3'h1;
        next_r.ack = 1'b0;
        next_r.err = 1'b0;
        next_r.ovf1_pulse = 1'b0;
        next_r.irq_last0 = irq0_s;
        next_r.irq_last1 = irq1_s;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        sum_lo0 = {1'b0, r.count_low_byte0} + 9'h001;
        sum_hi0 = {1'b0, r.count_high_byte0} + 9'h001;
        sum_lo1 = {1'b0, r.count_low_byte1} + 9'h001;
        sum_hi1 = {1'b0, r.count_high_byte1} + 9'h001;

        // Timer zero; run bit change never touches the counts
        if (tick0) begin // RL12
            case (mode0)
                DTC_MODE_13: begin
                    // Upper three low bits are left as they were
                    next_r.count_low_byte0[4:0] = sum_lo0[4:0]; // RL9
                    if (r.count_low_byte0[4:0] == 5'h1f) begin
                        next_r.count_high_byte0 = sum_hi0[7:0]; // RL9
                        ovf0 = sum_hi0[8]; // RL10
                    end
                end
                DTC_MODE_16: begin
                    next_r.count_low_byte0 = sum_lo0[7:0]; // RL13
                    if (sum_lo0[8]) begin
                        next_r.count_high_byte0 = sum_hi0[7:0]; // RL13
                        ovf0 = sum_hi0[8]; // RL10
                    end
                end
                DTC_MODE_RELOAD: begin
                    next_r.count_low_byte0 = sum_lo0[8] ? r.count_high_byte0
                        : sum_lo0[7:0]; // RL14
                    ovf0 = sum_lo0[8]; // RL14
                end
                DTC_MODE_SPLIT: begin
                    next_r.count_low_byte0 = sum_lo0[7:0]; // RL16
                    ovf0 = sum_lo0[8]; // RL16
                end
                default: begin
                    // Every mode is decoded above
                end
            endcase
        end
        if (tick0_hi) begin
            next_r.count_high_byte0 = sum_hi0[7:0]; // RL16
        end

        // Timer one
        if (tick1) begin
            case (mode1)
                DTC_MODE_13: begin
                    next_r.count_low_byte1[4:0] = sum_lo1[4:0]; // RL9
                    if (r.count_low_byte1[4:0] == 5'h1f) begin
                        next_r.count_high_byte1 = sum_hi1[7:0];
                        ovf1 = sum_hi1[8]; // RL10
                    end
                end
                DTC_MODE_16: begin
                    next_r.count_low_byte1 = sum_lo1[7:0]; // RL13
                    if (sum_lo1[8]) begin
                        next_r.count_high_byte1 = sum_hi1[7:0];
                        ovf1 = sum_hi1[8]; // RL10
                    end
                end
                DTC_MODE_RELOAD: begin
                    next_r.count_low_byte1 = sum_lo1[8] ? r.count_high_byte1
                        : sum_lo1[7:0]; // RL14
                    ovf1 = sum_lo1[8]; // RL14
                end
                default: begin
                    // Mode three never ticks, its enable is held low
                end
            endcase
        end
        // Overflow pulse keeps serving the serial port even in split mode
        next_r.ovf1_pulse = ovf1; // RL17

        // External interrupt detection on synchronised levels
        ext_set0 = r.timer_run_and_flag_control[EXT0_TYPE_BIT]
            ? (r.irq_last0 && !irq0_s) : !irq0_s; // RL20
        ext_set1 = r.timer_run_and_flag_control[EXT1_TYPE_BIT]
            ? (r.irq_last1 && !irq1_s) : !irq1_s; // RL20

        // Software writes first, hardware sets win over any clear
        ctl = r.timer_run_and_flag_control;
        if (wr) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    ctl = wbyte; // RL18
                end
                ADDR_MODE: begin
                    next_r.timer_mode_select = wbyte; // RL5
                end
                ADDR_CNT0_LO: begin
                    next_r.count_low_byte0 = wbyte; // RL21
                end
                ADDR_CNT1_LO: begin
                    next_r.count_low_byte1 = wbyte; // RL21
                end
                ADDR_CNT0_HI: begin
                    next_r.count_high_byte0 = wbyte; // RL21
                end
                ADDR_CNT1_HI: begin
                    next_r.count_high_byte1 = wbyte; // RL21
                end
                default: begin
                    // Service writes only clear flags below; unmapped writes leave the registers alone
                end
            endcase
        end
        if (ack_bits[ACK_OVF0_BIT]) begin
            ctl[OVF0_BIT] = 1'b0; // RL11
        end
        if (ack_bits[ACK_OVF1_BIT]) begin
            ctl[OVF1_BIT] = 1'b0; // RL11
        end
        if (ack_bits[ACK_EXT0_BIT]) begin
            ctl[EXT0_FLAG_BIT] = 1'b0; // RL19
        end
        if (ack_bits[ACK_EXT1_BIT]) begin
            ctl[EXT1_FLAG_BIT] = 1'b0; // RL19
        end
        if (ovf0) begin
            ctl[OVF0_BIT] = 1'b1; // RL10
        end
        // In split mode the high byte of timer zero owns the second flag
        if (mode0 == DTC_MODE_SPLIT) begin
            if (tick0_hi && sum_hi0[8]) begin
                ctl[OVF1_BIT] = 1'b1; // RL16
            end
        end else if (ovf1) begin
            ctl[OVF1_BIT] = 1'b1; // RL10
        end
        if (ext_set0) begin
            ctl[EXT0_FLAG_BIT] = 1'b1; // RL19
        end
        if (ext_set1) begin
            ctl[EXT1_FLAG_BIT] = 1'b1; // RL19
        end
        next_r.timer_run_and_flag_control = ctl;

        // Answer: ack for mapped addresses, err otherwise, one cycle later
        if (req) begin
            next_r.ack = hit;
            next_r.err = !hit;
            case (wb_adr_i)
                ADDR_CTRL: begin
                    next_r.rdata = {24'h000000, r.timer_run_and_flag_control};
                end
                ADDR_MODE: begin
                    next_r.rdata = {24'h000000, r.timer_mode_select};
                end
                ADDR_CNT0_LO: begin
                    next_r.rdata = {24'h000000, r.count_low_byte0};
                end
                ADDR_CNT1_LO: begin
                    next_r.rdata = {24'h000000, r.count_low_byte1};
                end
                ADDR_CNT0_HI: begin
                    next_r.rdata = {24'h000000, r.count_high_byte0};
                end
                ADDR_CNT1_HI: begin
                    next_r.rdata = {24'h000000, r.count_high_byte1};
                end
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
            r.timer_run_and_flag_control <= CTRL_RESET;
            r.timer_mode_select <= MODE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign wb_err_o = r.err;
    assign timer_one_overflow = r.ovf1_pulse;
    assign overflow_flag_zero = r.timer_run_and_flag_control[OVF0_BIT];
    assign overflow_flag_one = r.timer_run_and_flag_control[OVF1_BIT];
    assign ext_irq_flag_zero = r.timer_run_and_flag_control[EXT0_FLAG_BIT];
    assign ext_irq_flag_one = r.timer_run_and_flag_control[EXT1_FLAG_BIT];
endmodule
`default_nettype wire

// ===== dtc_chk.sv
`default_nettype none
module dtc_chk
    import dtc_pkg::*;
(
    // Clock and bus
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Pins and events
    input wire logic ext_irq_pin_one,
    input wire logic timer_one_overflow,
    input wire logic overflow_flag_zero,
    input wire logic overflow_flag_one
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    logic [7:0] mode_q;
    logic req, hit, ctl_wr, split, t1_stop;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit = wb_adr_i inside {ADDR_CTRL, ADDR_MODE, ADDR_CNT0_LO, ADDR_CNT1_LO,
        ADDR_CNT0_HI, ADDR_CNT1_HI, ADDR_IRQ_ACK};
    assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL;
    assign split = mode_q[1:0] == 2'b11;
    assign t1_stop = mode_q[5:4] == 2'b11;
    // Shadow lags the design by one cycle, hence the $past guards below
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_q <= MODE_RESET;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_MODE) begin
            mode_q <= wb_dat_i[7:0];
        end
    end
    AST_ACK_NEXT: assert property (req && hit |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");
    AST_ERR_NEXT: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    AST_ONE_PULSE: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("bus answer held too long");
    AST_SW_SET: assert property (ctl_wr |-> (overflow_flag_one || !wb_dat_i[OVF1_BIT])
        && (overflow_flag_zero || !wb_dat_i[OVF0_BIT])) else $error("flag write lost");
    AST_T1_RATE: assert property (timer_one_overflow |=> !timer_one_overflow [*5])
        else $error("timer one faster than machine cycle");
    AST_EDGE_RATE: assert property (timer_one_overflow && mode_q[6] && $past(mode_q[6], 2)
        |=> !timer_one_overflow [*8] ##1 !timer_one_overflow [*3])
        else $error("counter faster than two machine cycles");
    AST_T1_HOLD: assert property (t1_stop && $past(t1_stop, 2) |-> !timer_one_overflow)
        else $error("timer one ran in mode three");
    AST_GATE: assert property ((mode_q[7] && !ext_irq_pin_one) [*8] |-> !timer_one_overflow)
        else $error("gated timer one ran");
    AST_FLAG_SET: assert property (timer_one_overflow && !split && !$past(split, 2)
        |-> ##[0:1] overflow_flag_one) else $error("overflow did not set flag");
endmodule
bind dtc_top dtc_chk chk (.*);
`default_nettype wire

// ===== dtc_top_test.sv
`default_nettype none
module dtc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dtc_pkg::*;
    typedef struct {
        logic err;
        logic rd;
        logic [7:0] dat;
    } dtc_note_s;
    logic mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [7:0] wb_adr_i, r;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0] eirq, cpin;
    logic timer_one_overflow, overflow_flag_zero, overflow_flag_one;
    logic ext_irq_flag_zero, ext_irq_flag_one;
    wire logic ext_irq_pin_zero = eirq[0];
    wire logic ext_irq_pin_one = eirq[1];
    wire logic count_pin_zero = cpin[0];
    wire logic count_pin_one = cpin[1];
    wire logic [4:0] evt = {ext_irq_flag_one, ext_irq_flag_zero, overflow_flag_one,
        overflow_flag_zero, timer_one_overflow};
    dtc_note_s notes[$];
    dtc_note_s got;
    int fail_count, samples_checked, n;
    dtc_top uut (.*);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        dtc_note_s nt;
        nt.err = !(a inside {ADDR_CTRL, ADDR_MODE, ADDR_CNT0_LO, ADDR_CNT1_LO,
            ADDR_CNT0_HI, ADDR_CNT1_HI, ADDR_IRQ_ACK});
        nt.rd = !w && !nt.err;
        nt.dat = d;
        notes.push_back(nt);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h0, d};
        do @(posedge mclk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic await(input int b);
        n = 0;
        while (evt[b] !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        for (int t = 0; t < 2; t++) begin
            wb(ADDR_CNT0_LO + 8'(4 * t), 1'b1, lo);
            wb(ADDR_CNT0_HI + 8'(4 * t), 1'b1, hi);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
            got = notes.pop_front();
            chk("bus error", got.err, wb_err_o);
            if (got.rd) begin
                chk("read data", got.dat, wb_dat_o[7:0]);
            end
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        conclude();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        eirq = 2'b11;
        cpin = 2'b00;
        void'($urandom(32'h52af));
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        wb(ADDR_CTRL, 1'b0, CTRL_RESET);
        wb(ADDR_MODE, 1'b0, MODE_RESET);
        wb(8'h80, 1'b0, 8'h00);
        wb(8'ha0, 1'b1, 8'h5a);
        r = 8'($urandom());
        wb(ADDR_MODE, 1'b1, r);
        wb(ADDR_MODE, 1'b0, r);
        wb(ADDR_MODE, 1'b1, 8'h00);
        load(8'($urandom()), 8'h3c);
        wb(ADDR_CNT1_HI, 1'b0, 8'h3c);
        for (int t = 0; t < 2; t++) begin
            for (int e = 0; e < 2; e++) begin
                wb(ADDR_MODE, 1'b1, 8'(e) << (4 * t));
                wb(ADDR_CNT0_LO + 8'(4 * t), 1'b1, e ? 8'hfd : 8'h1e);
                wb(ADDR_CNT0_HI + 8'(4 * t), 1'b1, 8'hff);
                wb(ADDR_CTRL, 1'b1, 8'h10 << (2 * t));
                await(1 + t);
                chk("overflow delay", 1'b1, n >= 6 * e + 4 && n <= 6 * e + 14);
                wb(ADDR_CTRL, 1'b0, 8'h30 << (2 * t));
                wb(ADDR_IRQ_ACK, 1'b1, 8'h01 << t);
                chk("service clear", 1'b0, evt[1 + t]);
                wb(ADDR_CTRL, 1'b1, 8'h00);
            end
        end
        wb(ADDR_MODE, 1'b1, 8'h20);
        wb(ADDR_CNT1_HI, 1'b1, 8'hf0);
        wb(ADDR_CNT1_LO, 1'b1, 8'hfe);
        wb(ADDR_CTRL, 1'b1, 8'h40);
        await(0);
        @(posedge mclk);
        await(0);
        chk("reload period", 8'h60, 8'(n + 1));
        wb(ADDR_CTRL, 1'b0, 8'hc0);
        wb(ADDR_CTRL, 1'b1, 8'h00);
        wb(ADDR_CNT1_HI, 1'b0, 8'hf0);
        wb(ADDR_MODE, 1'b1, 8'h99);
        load(8'hfe, 8'hff);
        eirq <= 2'b00;
        wb(ADDR_CTRL, 1'b1, 8'h50);
        repeat (60) @(posedge mclk);
        chk("gated flags", 8'h00, {overflow_flag_one, overflow_flag_zero});
        chk("level flags", 8'h03, {ext_irq_flag_one, ext_irq_flag_zero});
        eirq <= 2'b11;
        await(2);
        chk("ungated", 1'b1, n < 24);
        wb(ADDR_MODE, 1'b1, 8'h55);
        load(8'hfe, 8'hff);
        wb(ADDR_CTRL, 1'b1, 8'h50);
        for (int i = 0; i < 2; i++) begin
            cpin <= 2'b11;
            repeat (8 + $urandom_range(3)) @(posedge mclk);
            cpin <= 2'b00;
            repeat (16) @(posedge mclk);
            chk("edge count", i ? 8'h03 : 8'h00, {overflow_flag_one, overflow_flag_zero});
        end
        wb(ADDR_CTRL, 1'b1, 8'h00);
        wb(ADDR_MODE, 1'b1, 8'h23);
        wb(ADDR_CNT0_HI, 1'b1, 8'hfe);
        wb(ADDR_CTRL, 1'b1, 8'h40);
        await(2);
        chk("split high byte", 1'b1, n < 20 && !overflow_flag_zero);
        await(0);
        chk("baud pulse", 1'b1, n < 1600);
        wb(ADDR_MODE, 1'b1, 8'h33);
        repeat (4) @(posedge mclk);
        await(0);
        chk("held timer", 1'b1, n == 2000);
        wb(ADDR_CTRL, 1'b1, 8'h00);
        wb(ADDR_MODE, 1'b1, 8'h00);
        wb(ADDR_CTRL, 1'b1, 8'haa);
        wb(ADDR_CTRL, 1'b0, 8'haa);
        for (int i = 0; i < 2; i++) begin
            wb(ADDR_CTRL, 1'b1, 8'h01 << (2 * i));
            eirq[i] <= 1'b0;
            repeat (6) @(posedge mclk);
            chk("edge flag", 1'b1, evt[3 + i]);
            wb(ADDR_IRQ_ACK, 1'b1, 8'h04 << i);
            chk("edge flag low", 1'b0, evt[3 + i]);
            wb(ADDR_CTRL, 1'b1, 8'h00);
            wb(ADDR_IRQ_ACK, 1'b1, 8'h04 << i);
            chk("level flag", 1'b1, evt[3 + i]);
            eirq[i] <= 1'b1;
            repeat (4) @(posedge mclk);
            wb(ADDR_IRQ_ACK, 1'b1, 8'h04 << i);
            chk("released flag", 1'b0, evt[3 + i]);
        end
        conclude();
    end
endmodule
`default_nettype wire
